/* File: verilog/bce_engine.sv */
// Colour expansion and raster operand front end of the block-transfer engine
`timescale 1ns/1ps
module bce_engine
  import bce_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  output logic                           fb_rd_req,
  output logic      [1:0]                fb_rd_kind,
  output logic      [bce_pkg::BCE_DIM_W-1:0] fb_rd_x,
  output logic      [bce_pkg::BCE_DIM_W-1:0] fb_rd_y,
  output logic      [1:0]                fb_rd_bytes,
  input  wire logic                      fb_rd_valid,
  input  wire logic [bce_pkg::BCE_DW-1:0] fb_rd_data,
  output logic                           host_src_ready,
  input  wire logic                      host_src_valid,
  input  wire logic [bce_pkg::BCE_DW-1:0] host_src_data,
  output logic                           out_valid,
  output logic                           out_we,
  output logic      [bce_pkg::BCE_DIM_W-1:0] out_x,
  output logic      [bce_pkg::BCE_DIM_W-1:0] out_y,
  output logic      [bce_pkg::BCE_DW-1:0] out_data,
  output logic      [1:0]                out_bytes,
  output logic                           busy
);
  import bce_pkg::*;

  // ==========================================================
  // Helper functions
  // Keep only the bytes that the configured depth carries
  function automatic logic [BCE_DW-1:0] depth_cut(input logic [BCE_DW-1:0] v, input logic [1:0] dep);
    case (dep)
      BCE_DEPTH_8:  depth_cut = {16'h0000, v[7:0]};
      BCE_DEPTH_16: depth_cut = {8'h00, v[15:0]};
      default:      depth_cut = v;
    endcase
  endfunction

  // Bytes moved per pixel
  function automatic logic [1:0] depth_bytes(input logic [1:0] dep);
    case (dep)
      BCE_DEPTH_8:  depth_bytes = BCE_BYTES_1;
      BCE_DEPTH_16: depth_bytes = BCE_BYTES_2;
      default:      depth_bytes = BCE_BYTES_3;
    endcase
  endfunction

  // Mono bit to colour pixel
  function automatic logic [BCE_DW-1:0] expand(input logic b, input logic [31:0] fg,
                                               input logic [31:0] bg, input logic [1:0] dep);
    expand = b ? depth_cut(fg[BCE_DW-1:0], dep) : depth_cut(bg[BCE_DW-1:0], dep);
  endfunction

  // Per-bit raster operation, index is {P,S,D}
  function automatic logic [BCE_DW-1:0] rop_apply(input logic [7:0] rop, input logic [BCE_DW-1:0] p,
                                                  input logic [BCE_DW-1:0] s, input logic [BCE_DW-1:0] d);
    for (int i = 0; i < BCE_DW; i++) begin
      rop_apply[i] = rop[{p[i], s[i], d[i]}];
    end
  endfunction

  // ==========================================================
  // Registers
  logic [1:0]  depth_r;
  logic [31:0] ctrl_r;
  logic [31:0] fg_r;
  logic [31:0] bg_r;
  logic [31:0] msc_r;
  logic [31:0] sfg_r;
  logic [31:0] sbg_r;
  logic [31:0] dwh_r;
  bce_state_e  state_r;
  logic [1:0]  op_r;
  logic [BCE_DIM_W-1:0] x_r;
  logic [BCE_DIM_W-1:0] y_r;
  logic [BCE_DW-1:0] s_r;
  logic [BCE_DW-1:0] p_r;
  logic [BCE_DW-1:0] d_r;
  logic [2:0]  m_r;

  // Decoded controls
  logic [7:0] rop;
  logic       use_s;
  logic       use_p;
  logic       use_d;
  logic       need;
  logic [1:0] msel;
  logic       start;
  logic [BCE_DIM_W-1:0] w_cfg;
  logic [BCE_DIM_W-1:0] h_cfg;
  logic       take;
  logic [BCE_DW-1:0] in_word;
  logic [31:0] sfg_sel;
  logic [31:0] sbg_sel;

  assign rop   = ctrl_r[BCE_ROP_LO +: 8];
  assign use_s = |((rop ^ (rop >> 2)) & BCE_USE_S);
  assign use_p = |((rop ^ (rop >> 4)) & BCE_USE_P);
  assign use_d = |((rop ^ (rop >> 1)) & BCE_USE_D);
  assign msel  = ctrl_r[BCE_MASK_LO +: 2];
  assign w_cfg = dwh_r[BCE_W_LO +: BCE_DIM_W];
  assign h_cfg = dwh_r[BCE_H_LO +: BCE_DIM_W];
  assign start = reg_wr && reg_addr == BCE_OFS_DWH && |reg_wdata[BCE_H_LO +: BCE_DIM_W] && !busy;
  // Operand fetched when the operation or the write mask reads it
  assign need  = (op_r == BCE_OP_SRC && use_s) || (op_r == BCE_OP_PAT && use_p) ||
                 (op_r == BCE_OP_DST && use_d) || (msel == op_r + 2'h1);
  assign take    = host_src_ready ? host_src_valid : fb_rd_valid;
  assign in_word = host_src_ready ? host_src_data : fb_rd_data;
  // Source colour pair, shared unless bit 27 asks for its own
  assign sfg_sel = msc_r[BCE_SRC_SEP] ? sfg_r : fg_r;
  assign sbg_sel = msc_r[BCE_SRC_SEP] ? sbg_r : bg_r;

  // ==========================================================
  // Register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      depth_r <= BCE_DEPTH_8;
      ctrl_r  <= BCE_RST_ZERO;
      fg_r    <= BCE_RST_ZERO;
      bg_r    <= BCE_RST_ZERO;
      msc_r   <= BCE_RST_ZERO;
      sfg_r   <= BCE_RST_ZERO;
      sbg_r   <= BCE_RST_ZERO;
      dwh_r   <= BCE_RST_ZERO;
    end else if (reg_wr && !busy) begin
      case (reg_addr)
        BCE_OFS_DEPTH: depth_r <= (reg_wdata[1:0] == 2'h3) ? BCE_DEPTH_24 : reg_wdata[1:0];
        BCE_OFS_CTRL:  ctrl_r  <= reg_wdata;
        BCE_OFS_FG:    fg_r    <= reg_wdata;
        BCE_OFS_BG:    bg_r    <= reg_wdata;
        BCE_OFS_MSC:   msc_r   <= reg_wdata;
        BCE_OFS_SFG:   sfg_r   <= reg_wdata;
        BCE_OFS_SBG:   sbg_r   <= reg_wdata;
        BCE_OFS_DWH:   dwh_r   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= BCE_RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        BCE_OFS_DEPTH: reg_rdata <= {30'h0, depth_r};
        BCE_OFS_CTRL:  reg_rdata <= ctrl_r;
        BCE_OFS_FG:    reg_rdata <= fg_r;
        BCE_OFS_BG:    reg_rdata <= bg_r;
        BCE_OFS_MSC:   reg_rdata <= msc_r;
        BCE_OFS_SFG:   reg_rdata <= sfg_r;
        BCE_OFS_SBG:   reg_rdata <= sbg_r;
        BCE_OFS_DWH:   reg_rdata <= dwh_r;
        BCE_OFS_STAT:  reg_rdata <= {3'h0, y_r, 15'h0, busy};
        default:       reg_rdata <= BCE_RST_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Transfer sequencer: fetch whichever of S, P, D are needed, in turn, then emit one pixel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r        <= BCE_IDLE;
      op_r           <= BCE_OP_SRC;
      x_r            <= '0;
      y_r            <= '0;
      busy           <= 1'b0;
      fb_rd_req      <= 1'b0;
      fb_rd_kind     <= BCE_OP_SRC;
      fb_rd_x        <= '0;
      fb_rd_y        <= '0;
      fb_rd_bytes    <= BCE_BYTES_1;
      host_src_ready <= 1'b0;
    end else begin
      fb_rd_req <= 1'b0;
      case (state_r)
        BCE_IDLE: begin
          if (start) begin
            busy    <= 1'b1;
            x_r     <= '0;
            y_r     <= '0;
            op_r    <= BCE_OP_SRC;
            state_r <= BCE_REQ;
          end
        end
        BCE_REQ: begin
          if (op_r == BCE_OP_DONE) begin
            state_r <= BCE_EMIT;
          end else if (!need) begin
            op_r <= op_r + 2'h1;
          end else if (op_r == BCE_OP_SRC && ctrl_r[BCE_SRC_HOST]) begin
            host_src_ready <= 1'b1;
            state_r        <= BCE_WAIT;
          end else begin
            fb_rd_req   <= 1'b1;
            fb_rd_kind  <= op_r;
            fb_rd_bytes <= depth_bytes(depth_r);
            // Pattern reads wrap inside the 8x8 tile
            fb_rd_x <= (op_r == BCE_OP_PAT) ? (x_r % BCE_DIM_W'(BCE_PAT_SIZE)) : x_r;
            fb_rd_y <= (op_r == BCE_OP_PAT) ? (y_r % BCE_DIM_W'(BCE_PAT_SIZE)) : y_r;
            state_r <= BCE_WAIT;
          end
        end
        BCE_WAIT: begin
          if (take) begin
            host_src_ready <= 1'b0;
            op_r           <= op_r + 2'h1;
            state_r        <= BCE_REQ;
          end
        end
        BCE_EMIT: begin
          op_r <= BCE_OP_SRC;
          if (x_r == w_cfg - 1'b1 || w_cfg == '0) begin
            x_r <= '0;
            if (y_r == h_cfg - 1'b1) begin
              busy    <= 1'b0;
              state_r <= BCE_IDLE;
            end else begin
              y_r     <= y_r + 1'b1;
              state_r <= BCE_REQ;
            end
          end else begin
            x_r     <= x_r + 1'b1;
            state_r <= BCE_REQ;
          end
        end
        default: state_r <= BCE_IDLE;
      endcase
    end
  end

  // Operand capture with colour expansion of mono source and pattern
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      p_r <= '0;
      d_r <= '0;
      m_r <= '0;
    end else if (state_r == BCE_IDLE) begin
      s_r <= '0;
      p_r <= '0;
      d_r <= '0;
      m_r <= '0;
    end else if (state_r == BCE_WAIT && take) begin
      case (op_r)
        BCE_OP_SRC: begin
          s_r    <= ctrl_r[BCE_SRC_MONO] ? expand(in_word[0], sfg_sel, sbg_sel, depth_r)
                                         : depth_cut(in_word, depth_r);
          m_r[0] <= ctrl_r[BCE_SRC_MONO] ? in_word[0] : |depth_cut(in_word, depth_r);
        end
        BCE_OP_PAT: begin
          p_r    <= ctrl_r[BCE_PAT_MONO] ? expand(in_word[0], fg_r, bg_r, depth_r)
                                         : depth_cut(in_word, depth_r);
          m_r[1] <= ctrl_r[BCE_PAT_MONO] ? in_word[0] : |depth_cut(in_word, depth_r);
        end
        default: begin
          d_r    <= depth_cut(in_word, depth_r);
          m_r[2] <= |depth_cut(in_word, depth_r);
        end
      endcase
    end
  end

  // Pixel output with per-pixel write mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_we    <= 1'b0;
      out_x     <= '0;
      out_y     <= '0;
      out_data  <= '0;
      out_bytes <= BCE_BYTES_1;
    end else begin
      out_valid <= state_r == BCE_EMIT;
      if (state_r == BCE_EMIT) begin
        out_x     <= x_r;
        out_y     <= y_r;
        out_bytes <= depth_bytes(depth_r);
        out_data  <= depth_cut(rop_apply(rop, p_r, s_r, d_r), depth_r);
        out_we    <= (msel == BCE_MSK_NONE) ? 1'b1 : m_r[msel - 2'h1];
      end
    end
  end

  // ==========================================================
  // Checks
  start_busy_a: assert property (@(posedge ref_clk) disable iff (rst) start |=> busy)
    else $error("transfer did not start");
  zero_height_a: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == BCE_OFS_DWH && reg_wdata[BCE_H_LO +: BCE_DIM_W] == '0 && !busy) |=> !busy)
    else $error("zero height started a transfer");
  unused_fetch_a: assert property (@(posedge ref_clk) disable iff (rst)
      fb_rd_req |-> ((fb_rd_kind == BCE_OP_SRC && (use_s || msel == BCE_MSK_SRC)) ||
                     (fb_rd_kind == BCE_OP_PAT && (use_p || msel == BCE_MSK_PAT)) ||
                     (fb_rd_kind == BCE_OP_DST && (use_d || msel == BCE_MSK_DST))))
    else $error("unused operand fetched");
  dest_host_a: assert property (@(posedge ref_clk) disable iff (rst) host_src_ready |-> op_r == BCE_OP_SRC)
    else $error("host asked for non-source data");
  pat_tile_a: assert property (@(posedge ref_clk) disable iff (rst)
      (fb_rd_req && fb_rd_kind == BCE_OP_PAT) |-> (fb_rd_x < BCE_PAT_SIZE && fb_rd_y < BCE_PAT_SIZE))
    else $error("pattern read outside tile");
  depth_bytes_a: assert property (@(posedge ref_clk) disable iff (rst)
      out_valid |-> (out_bytes == depth_bytes(depth_r) && out_data == depth_cut(out_data, depth_r)))
    else $error("output wider than depth");
  src_expand_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == BCE_WAIT && take && op_r == BCE_OP_SRC && ctrl_r[BCE_SRC_MONO]) |=>
      s_r == ($past(in_word[0]) ? depth_cut($past(sfg_sel[BCE_DW-1:0]), depth_r)
                         : depth_cut($past(sbg_sel[BCE_DW-1:0]), depth_r)))
    else $error("source expansion colour wrong");
  pat_expand_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state_r == BCE_WAIT && take && op_r == BCE_OP_PAT && ctrl_r[BCE_PAT_MONO] && !fb_rd_data[0]) |=>
      p_r == depth_cut(bg_r[BCE_DW-1:0], depth_r))
    else $error("pattern background wrong");
  rop_out_a: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == BCE_EMIT |=> out_valid && out_data == depth_cut(rop_apply($past(rop), p_r, s_r, d_r), depth_r))
    else $error("raster result wrong");
  cov_host_c:  cover property (@(posedge ref_clk) disable iff (rst) host_src_ready && host_src_valid);
  cov_mono_c:  cover property (@(posedge ref_clk) disable iff (rst) out_valid && ctrl_r[BCE_SRC_MONO]);
  cov_mask_c:  cover property (@(posedge ref_clk) disable iff (rst) out_valid && !out_we);
  cov_done_c:  cover property (@(posedge ref_clk) disable iff (rst) busy ##1 !busy);
endmodule // bce_engine

/* File: include/bce_pkg.sv */
// Shared constants for the block-transfer colour expansion front end
package bce_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] BCE_OFS_DEPTH = 8'h00; // blit_depth_config
  localparam logic [7:0] BCE_OFS_CTRL  = 8'h04; // blit_control
  localparam logic [7:0] BCE_OFS_FG    = 8'h08; // expand_fg_color
  localparam logic [7:0] BCE_OFS_BG    = 8'h0C; // expand_bg_color
  localparam logic [7:0] BCE_OFS_MSC   = 8'h10; // mono_source_control
  localparam logic [7:0] BCE_OFS_SFG   = 8'h14; // source_fg_color
  localparam logic [7:0] BCE_OFS_SBG   = 8'h18; // source_bg_color
  localparam logic [7:0] BCE_OFS_DWH   = 8'h1C; // dest_width_height
  localparam logic [7:0] BCE_OFS_STAT  = 8'h20; // engine status
  // ==========================================================
  // Field positions
  localparam int BCE_ROP_LO      = 0;   // Raster operation code, 8 bits
  localparam int BCE_SRC_MONO    = 12;  // Source is monochrome
  localparam int BCE_SRC_HOST    = 14;  // Source comes from the host
  localparam int BCE_PAT_MONO    = 18;  // Pattern is monochrome
  localparam int BCE_MASK_LO     = 20;  // Write mask operand select, 2 bits
  localparam int BCE_SRC_SEP     = 27;  // Separate source colour pair
  localparam int BCE_W_LO        = 0;   // Width in pixels, 13 bits
  localparam int BCE_H_LO        = 16;  // Height in lines, 13 bits
  localparam int BCE_DIM_W       = 13;
  localparam int BCE_DW          = 24;  // Widest pixel, 3 bytes
  localparam int BCE_PAT_SIZE    = 8;   // Pattern tile edge in pixels
  // ==========================================================
  // Depth codes and byte counts
  localparam logic [1:0] BCE_DEPTH_8  = 2'h0;
  localparam logic [1:0] BCE_DEPTH_16 = 2'h1;
  localparam logic [1:0] BCE_DEPTH_24 = 2'h2;
  localparam logic [1:0] BCE_BYTES_1  = 2'h1;
  localparam logic [1:0] BCE_BYTES_2  = 2'h2;
  localparam logic [1:0] BCE_BYTES_3  = 2'h3;
  // ==========================================================
  // Operand kinds and mask selections
  localparam logic [1:0] BCE_OP_SRC  = 2'h0;
  localparam logic [1:0] BCE_OP_PAT  = 2'h1;
  localparam logic [1:0] BCE_OP_DST  = 2'h2;
  localparam logic [1:0] BCE_OP_DONE = 2'h3;
  localparam logic [1:0] BCE_MSK_NONE = 2'h0;
  localparam logic [1:0] BCE_MSK_SRC  = 2'h1;
  localparam logic [1:0] BCE_MSK_PAT  = 2'h2;
  localparam logic [1:0] BCE_MSK_DST  = 2'h3;
  // Operand use masks inside the raster code
  localparam logic [7:0] BCE_USE_D = 8'h55;
  localparam logic [7:0] BCE_USE_S = 8'h33;
  localparam logic [7:0] BCE_USE_P = 8'h0F;
  // Reset values
  localparam logic [31:0] BCE_RST_ZERO = 32'h0000_0000;
  // Engine states
  typedef enum logic [1:0] {BCE_IDLE, BCE_REQ, BCE_WAIT, BCE_EMIT} bce_state_e;
endpackage

/* File: dv/bce_fb_model.sv */
// Frame buffer memory and host source model facing the engine
`timescale 1ns/1ps
module bce_fb_model (
  input  wire logic                        ref_clk,
  input  wire logic                        slow,
  input  wire logic                        fb_rd_req,
  input  wire logic [1:0]                  fb_rd_kind,
  input  wire logic [bce_pkg::BCE_DIM_W-1:0] fb_rd_x,
  input  wire logic [bce_pkg::BCE_DIM_W-1:0] fb_rd_y,
  output logic                             fb_rd_valid,
  output logic      [bce_pkg::BCE_DW-1:0]  fb_rd_data,
  input  wire logic                        host_src_ready,
  output logic                             host_src_valid,
  output logic      [bce_pkg::BCE_DW-1:0]  host_src_data
);
  import bce_pkg::*;
  logic [1:0]  kind_r = 2'h0;
  logic [12:0] x_r    = 13'h0000;
  logic [12:0] y_r    = 13'h0000;
  logic        pend_r = 1'b0;
  logic [2:0]  fw_r   = 3'h0;
  logic [2:0]  hw_r   = 3'h0;
  logic [7:0]  cnt_r  = 8'h00;
  initial fb_rd_valid = 1'b0;
  initial fb_rd_data = 24'h000000;
  initial host_src_valid = 1'b0;
  initial host_src_data = 24'h000000;
  // ==========================================================
  // Memory contents, a plain function of operand kind and place
  function automatic logic [23:0] fb_word(input logic [1:0] k, input logic [12:0] x, input logic [12:0] y);
    case (k)
      2'h0: return {16'hC35A, x[7:0]};
      2'h1: return {16'h0F96, 5'h00, y[2:0]};
      default: return {16'h3C69, y[7:0]};
    endcase
  endfunction
  // Read answers after a short or long delay; data inverted once released
  always @(posedge ref_clk) begin
    fb_rd_valid <= 1'b0;
    if (fb_rd_valid) fb_rd_data <= ~fb_rd_data;
    if (fb_rd_req) begin
      pend_r <= 1'b1;
      fw_r   <= slow ? 3'h3 : 3'h0;
      kind_r <= fb_rd_kind;
      x_r    <= fb_rd_x;
      y_r    <= fb_rd_y;
    end else if (pend_r && fw_r != 3'h0) begin
      fw_r <= fw_r - 3'h1;
    end else if (pend_r) begin
      fb_rd_valid <= 1'b1;
      fb_rd_data  <= fb_word(kind_r, x_r, y_r);
      pend_r      <= 1'b0;
    end
  end
  // Host source words held until taken, numbered in order of hand-over
  always @(posedge ref_clk) begin
    if (host_src_valid && host_src_ready) begin
      host_src_valid <= 1'b0;
      host_src_data  <= ~host_src_data;
      cnt_r          <= cnt_r + 8'h01;
      hw_r           <= slow ? 3'h3 : 3'h0;
    end else if (host_src_ready && !host_src_valid && hw_r != 3'h0) begin
      hw_r <= hw_r - 3'h1;
    end else if (host_src_ready && !host_src_valid) begin
      host_src_valid <= 1'b1;
      host_src_data  <= {16'h7E81, cnt_r};
    end
  end
endmodule // bce_fb_model

/* File: dv/tb.sv */
// Register-driven tests of the colour expansion front end
`timescale 1ns/1ps
module tb;
  import bce_pkg::*;
  localparam logic [23:0] FGC = 24'hA5C3E7;
  localparam logic [23:0] BGC = 24'h5A3C18;
  localparam logic [23:0] SFC = 24'hF00F96;
  localparam logic [23:0] SBC = 24'h0FF069;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic fb_rd_req, fb_rd_valid, host_src_ready, host_src_valid, out_valid, out_we, busy;
  logic [1:0] fb_rd_kind, fb_rd_bytes, out_bytes, eb = 2'h1;
  logic [12:0] fb_rd_x, fb_rd_y, out_x, out_y;
  logic [23:0] fb_rd_data, host_src_data, out_data;
  logic [63:0] out_q[$];
  int errors = 0, checked = 0, tn = 0, host_n = 0, host_base = 0, a;
  int req_n[4];
  bce_engine i_bce_engine (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fb_rd_req(fb_rd_req), .fb_rd_kind(fb_rd_kind),
    .fb_rd_x(fb_rd_x), .fb_rd_y(fb_rd_y), .fb_rd_bytes(fb_rd_bytes), .fb_rd_valid(fb_rd_valid),
    .fb_rd_data(fb_rd_data), .host_src_ready(host_src_ready), .host_src_valid(host_src_valid),
    .host_src_data(host_src_data), .out_valid(out_valid), .out_we(out_we), .out_x(out_x), .out_y(out_y),
    .out_data(out_data), .out_bytes(out_bytes), .busy(busy));
  bce_fb_model i_bce_fb_model (.ref_clk(ref_clk), .slow(slow), .fb_rd_req(fb_rd_req), .fb_rd_kind(fb_rd_kind),
    .fb_rd_x(fb_rd_x), .fb_rd_y(fb_rd_y), .fb_rd_valid(fb_rd_valid), .fb_rd_data(fb_rd_data),
    .host_src_ready(host_src_ready), .host_src_valid(host_src_valid), .host_src_data(host_src_data));
  // ==========================================================
  // Clock, compare and bus tasks
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] da);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= da;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic end_sim;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watches requests and results at every rising edge
  always @(posedge ref_clk) begin
    if (fb_rd_req) begin
      req_n[fb_rd_kind]++;
      chk(fb_rd_bytes, eb);
      if (fb_rd_kind == BCE_OP_PAT) chk((fb_rd_x | fb_rd_y) >> 3, 0);
    end
    if (host_src_ready && host_src_valid) host_n++;
    if (out_valid) out_q.push_back({out_we, out_bytes, out_y, out_x, out_data});
  end
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge ref_clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n < 3000, 1'b1);
    repeat (2) @(posedge ref_clk);
  endtask
  // Runs one transfer and checks every pixel and every fetch
  task automatic blit(input logic [1:0] dep, input logic [31:0] ctl, input logic [31:0] msc, input int w, h);
    int n, x, y;
    logic [23:0] s, p, d, se, pe, r, m;
    logic [7:0] rop;
    logic [1:0] ms;
    logic we;
    rop = ctl[7:0];
    ms = ctl[21:20];
    m = dep == 2'h0 ? 24'hFF : dep == 2'h1 ? 24'hFFFF : 24'hFFFFFF;
    eb = dep + 2'h1;
    req_n = '{default: 0};
    host_n = 0;
    out_q.delete();
    wr(BCE_OFS_DEPTH, {30'h0, dep});
    wr(BCE_OFS_CTRL, ctl);
    wr(BCE_OFS_MSC, msc);
    wr(BCE_OFS_DWH, {3'h0, 13'(h), 3'h0, 13'(w)});
    wait_idle();
    chk(out_q.size(), w * h);
    for (n = 0; n < w * h; n++) begin
      x = n % w;
      y = n / w;
      s = ctl[14] ? {16'h7E81, 8'(host_base + n)} : i_bce_fb_model.fb_word(2'h0, 13'(x), 13'(y));
      p = i_bce_fb_model.fb_word(2'h1, 13'(x % 8), 13'(y % 8));
      d = i_bce_fb_model.fb_word(2'h2, 13'(x), 13'(y));
      se = !ctl[12] ? s : msc[27] ? (s[0] ? SFC : SBC) : (s[0] ? FGC : BGC);
      pe = !ctl[18] ? p : (p[0] ? FGC : BGC);
      for (int b = 0; b < 24; b++) r[b] = rop[{pe[b], se[b], d[b]}];
      we = ms == 2'h0 ? 1'b1 : ms == 2'h1 ? (ctl[12] ? s[0] : |(s & m)) :
           ms == 2'h2 ? (ctl[18] ? p[0] : |(p & m)) : |(d & m);
      chk(out_q[n], {11'h0, we, eb, 13'(y), 13'(x), r & m});
    end
    chk(req_n[0], (|((rop ^ (rop >> 2)) & 8'h33) || ms == 2'h1) && !ctl[14] ? w * h : 0);
    chk(req_n[1], (|((rop ^ (rop >> 4)) & 8'h0F) || ms == 2'h2) ? w * h : 0);
    chk(req_n[2], (|((rop ^ (rop >> 1)) & 8'h55) || ms == 2'h3) ? w * h : 0);
    chk(host_n, ctl[14] ? w * h : 0);
    if (ctl[14]) host_base += w * h;
    $display("test %0d done", ++tn);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (a = 0; a <= 8'h24; a += 4) begin
      rd(8'(a));
      chk(rv, BCE_RST_ZERO);
    end
    wr(BCE_OFS_DEPTH, 32'h3);
    rd(BCE_OFS_DEPTH);
    chk(rv, 32'h2);
    $display("test %0d done", ++tn);
    wr(BCE_OFS_FG, {8'h11, FGC});
    wr(BCE_OFS_BG, {8'h22, BGC});
    wr(BCE_OFS_SFG, {8'h33, SFC});
    wr(BCE_OFS_SBG, {8'h44, SBC});
    blit(2'h0, 32'h0000_00CC, 32'h0, 3, 2);
    blit(2'h1, 32'h0024_00F0, 32'h0, 9, 2);
    blit(2'h2, 32'h0010_50CC, 32'h0800_0000, 3, 1);
    slow <= 1'b1;
    blit(2'h2, 32'h0000_50CC, 32'h0, 2, 2);
    blit(2'h0, 32'h0030_0096, 32'h0, 2, 2);
    slow <= 1'b0;
    blit(2'h1, 32'h0000_10CC, 32'h0800_0000, 2, 1);
    blit(2'h1, 32'h0000_00AA, 32'h0, 2, 2);
    wr(BCE_OFS_DWH, 32'h0000_0005);
    repeat (3) @(posedge ref_clk);
    chk(busy, 1'b0);
    wr(BCE_OFS_CTRL, 32'h0);
    wr(BCE_OFS_DWH, 32'h0004_0004);
    wr(BCE_OFS_CTRL, 32'hFF);
    rd(BCE_OFS_STAT);
    chk(rv[0], 1'b1);
    wait_idle();
    rd(BCE_OFS_CTRL);
    chk(rv, 32'h0);
    $display("test %0d done", ++tn);
    end_sim();
  end
  // Watchdog at 20000 cycles, far beyond the few hundred cycles the tests take
  initial begin
    #100000;
    errors++;
    end_sim();
  end
endmodule // tb
